// File: synth_regs_pkg.sv
// package for the synthesizer control word bank
// assumes words arrive already deserialised as 27-bit values with an index
package synth_regs_pkg;
   localparam int          WORD_W          = 27;
   localparam logic [3:0]  IDX_MASTER      = 4'h0;
   localparam logic [3:0]  IDX_MODULUS     = 4'h2;
   localparam logic [3:0]  IDX_REFDIV      = 4'h3;
   localparam logic [3:0]  IDX_LOCK        = 4'h4;
   localparam int          DBUF_BIT        = 26;
   localparam logic [26:0] MODULUS_RESET   = 27'h0000002;
   localparam logic [26:0] REFDIV_RESET    = 27'h0000001;
   localparam logic [26:0] LOCK_RESET      = 27'h0000309;
   // lock window base step, and largest lock count
   localparam int          WINDOW_STEP_NS  = 2;
   localparam int          CLK_PERIOD_PS   = 5000;
   localparam int          WINDOW_STEP_CYC = (WINDOW_STEP_NS * 1000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
   localparam int          LOCK_CNT_MAX    = 4096;

   typedef struct packed {
      logic        valid;
      logic [3:0]  index;
      logic [26:0] data;
   } word_write_t;

   typedef struct packed {
      logic        device_power_down;
      logic        output2_power_down;
      logic [20:0] fraction_denominator;
      logic        leakage_direction;
      logic [5:0]  leakage_current_step;
      logic        down_split_enable;
      logic [1:0]  detector_delay_mode;
      logic [1:0]  reference_path;
      logic [12:0] reference_divider;
      logic        external_oscillator_enable;
      logic        internal_oscillator_on;
      logic        gain_compensation_auto;
      logic        detector_polarity;
      logic [1:0]  reference_buffer_mode;
   } synth_ctrl_t;
endpackage

// File: synth_control_regs_2_to_4.sv
// register bank for the modulus, reference divider and lock control words
// assumes a serial front end hands over complete words on ref_clk; the
// detector compare pulse and phase error arrive from the detector clock domain
`timescale 1ns/10ps

// Overview of operation
// R1: with buffer bit set, written word waits in shadow until master word written.
// R2: host keeps modulator clock test bit at zero.
// R3: host writes zero to all reserved fields.
// R4: output2 power down bit disables second output; host sets it when first enabled.
// R5: 21-bit modulus is fraction denominator, host range 2 to 2097151.
// R6: device power down switches off all blocks except regulators; down_split_level still follows master_delay_value while r[17] is set.
// R7: leakage current equals code times 10 or 20 microamp step.
// R8: leakage direction zero sinks, one sources.
// R9: down split enable adds pulse current set by master word delay field.
// R10: delay mode selects none, feedback delayed, reference delayed; 11 reserved.
// R11: reference path direct, doubled, halved, quartered; no doubling when differential.
// R12: 13-bit reference divider, host range 1 to 8191.
// R13: external oscillator enable powers internal oscillators down.
// R14: host limits oscillator amplitude by core supply.
// R15: gain compensation disable fixes pump current; zero auto adjusts.
// R16: detector polarity zero standard, one inverted.
// R17: reference buffer 01 differential, 10 crystal, 11 single ended; 00 reserved.
// R18: mute enable switches outputs off while loop unlocked.
// R19: lock polarity zero gives high when locked, one low.
// R20: lock window is 2 ns times code plus one; code rounds the step up to one 5 ns ref_clk cycle, so code plus one cycles.
// R21: lock count select maps to 4 through 4096 comparisons.
// R22: host sets supply bits to match the supplies.
// R23: host keeps numerator below modulus.
// R24: with buffer bit clear a write takes effect at once.
// R25: lock after required consecutive in-window compares; clear on first outside.
module synth_control_regs_2_to_4
   import synth_regs_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   input  wire word_write_t word_in,
   input  wire logic [1:0]  master_delay_value,
   input  wire logic        compare_clk,
   input  wire logic [7:0]  phase_error_cycles,
   output logic [26:0]      modulus_and_output2_ctrl,
   output logic [26:0]      ref_divider_and_leakage_ctrl,
   output logic [26:0]      lock_detect_and_buffer_ctrl,
   output synth_ctrl_t      ctrl,
   output logic [1:0]       down_split_level,
   output logic             output_mute,
   output logic             lock_indicator
);

   ////////////////////////////////////////////////////////////////////////////
   logic        wr_master;

   assign wr_master = word_in.valid && (word_in.index == IDX_MASTER);

   // one slot per control word, each with its own shadow stage and pending flag
   word_slot #(
      .INDEX       (IDX_MODULUS),
      .RESET_VALUE (MODULUS_RESET)
   ) mod_slot (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .clk_en    (clk_en),
      .word_in   (word_in),
      .wr_master (wr_master),
      .active    (modulus_and_output2_ctrl)
   );

   word_slot #(
      .INDEX       (IDX_REFDIV),
      .RESET_VALUE (REFDIV_RESET)
   ) ref_slot (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .clk_en    (clk_en),
      .word_in   (word_in),
      .wr_master (wr_master),
      .active    (ref_divider_and_leakage_ctrl)
   );

   word_slot #(
      .INDEX       (IDX_LOCK),
      .RESET_VALUE (LOCK_RESET)
   ) lock_slot (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .clk_en    (clk_en),
      .word_in   (word_in),
      .wr_master (wr_master),
      .active    (lock_detect_and_buffer_ctrl)
   );

   ////////////////////////////////////////////////////////////////////////////
   logic [26:0] m;
   logic [26:0] r;
   logic [26:0] l;
   logic        pd;
   assign m  = modulus_and_output2_ctrl;
   assign r  = ref_divider_and_leakage_ctrl;
   assign l  = lock_detect_and_buffer_ctrl;
   assign pd = r[25];

   // decoded controls of the modulus word, plus the power down bit of the reference divider word
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl.device_power_down    <= 1'b0;
         ctrl.output2_power_down   <= 1'b0;
         ctrl.fraction_denominator <= 21'h000000;
      end else if (clk_en) begin
         ctrl.device_power_down    <= pd; // see R6
         ctrl.output2_power_down   <= m[21] | pd; // see R4
         ctrl.fraction_denominator <= m[20:0]; // see R5
      end
   end

   // decoded controls of the reference divider word
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl.leakage_direction    <= 1'b0;
         ctrl.leakage_current_step <= 6'h00;
         ctrl.down_split_enable    <= 1'b0;
         ctrl.detector_delay_mode  <= 2'h0;
         ctrl.reference_path       <= 2'h0;
         ctrl.reference_divider    <= 13'h0000;
         down_split_level          <= 2'h0;
      end else if (clk_en) begin
         ctrl.leakage_direction    <= r[18]; // see R8
         // leakage in 10 uA units: code, doubled when step bit set
         ctrl.leakage_current_step <= pd ? 6'h00 :
                                      (r[24] ? {r[23:19], 1'b0} : {1'b0, r[23:19]}); // see R7
         ctrl.down_split_enable    <= r[17] & ~pd; // see R9
         ctrl.detector_delay_mode  <= (r[16:15] == 2'h3) ? 2'h0 : r[16:15]; // see R10
         ctrl.reference_path       <= r[14:13]; // see R11
         ctrl.reference_divider    <= r[12:0]; // see R12
         down_split_level <= r[17] ? master_delay_value : 2'h0; // see R9
      end
   end

   // decoded controls of the lock and buffer word
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl.external_oscillator_enable <= 1'b0;
         ctrl.internal_oscillator_on     <= 1'b0;
         ctrl.gain_compensation_auto     <= 1'b0;
         ctrl.detector_polarity          <= 1'b0;
         ctrl.reference_buffer_mode      <= 2'h0;
      end else if (clk_en) begin
         ctrl.external_oscillator_enable <= l[19] & ~pd; // see R13
         ctrl.internal_oscillator_on     <= ~l[19] & ~pd; // see R13
         ctrl.gain_compensation_auto     <= ~l[11]; // see R15
         ctrl.detector_polarity          <= l[10]; // see R16
         ctrl.reference_buffer_mode      <= l[9:8]; // see R17
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // compare clock comes from the detector domain: two-flop sync then edge find
   // the error only moves half a compare period away from the rising edge
   logic       cmp_s2;
   logic       cmp_s3;
   logic [7:0] err_s2;

   sync_stage #(
      .WIDTH (1)
   ) cmp_sync (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .clk_en   (clk_en),
      .async_in (compare_clk),
      .sync_out (cmp_s2)
   );

   sync_stage #(
      .WIDTH (8)
   ) err_sync (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .clk_en   (clk_en),
      .async_in (phase_error_cycles),
      .sync_out (err_s2)
   );

   // delayed copy for edge finding; reset level matches the idle pin
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cmp_s3 <= 1'b0;
      end else if (clk_en) begin
         cmp_s3 <= cmp_s2;
      end
   end

   logic        cmp_edge;
   logic [7:0]  window_cyc;
   logic [12:0] need_cnt;
   logic [12:0] good_cnt;
   logic        locked;
   assign cmp_edge   = cmp_s2 & ~cmp_s3;
   assign window_cyc = 8'((int'(l[5:3]) + 1) * WINDOW_STEP_CYC); // see R20

   always_comb begin
      unique case (l[2:0]) // see R21
         3'h0: need_cnt = 13'h0004;
         3'h1: need_cnt = 13'h0008;
         3'h2: need_cnt = 13'h0010;
         3'h3: need_cnt = 13'h0040;
         3'h4: need_cnt = 13'h0100;
         3'h5: need_cnt = 13'h0400;
         3'h6: need_cnt = 13'h0800;
         3'h7: need_cnt = 13'(LOCK_CNT_MAX);
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         good_cnt <= 13'h0000;
         locked   <= 1'b0;
      end else if (clk_en && pd) begin
         // power down drops lock, but only while the clock is enabled
         good_cnt <= 13'h0000;
         locked   <= 1'b0;
      end else if (clk_en && cmp_edge) begin
         if (err_s2 > window_cyc) begin
            good_cnt <= 13'h0000; // see R25
            locked   <= 1'b0; // see R25
         end else if (good_cnt + 13'h0001 >= need_cnt) begin
            good_cnt <= need_cnt;
            locked   <= 1'b1; // see R25
         end else begin
            good_cnt <= good_cnt + 13'h0001;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lock_indicator <= 1'b0;
         output_mute    <= 1'b0;
      end else if (clk_en) begin
         lock_indicator <= locked ^ l[6]; // see R19
         output_mute    <= pd | (l[7] & ~locked); // see R18
      end
   end

endmodule

////////////////////////////////////////////////////////////////////////////////
// one control word: shadow stage, pending flag and active stage
module word_slot
   import synth_regs_pkg::*;
#(
   parameter logic [3:0]  INDEX       = 4'h2,
   parameter logic [26:0] RESET_VALUE = 27'h0000000
)
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   input  wire word_write_t word_in,
   input  wire logic        wr_master,
   output logic [26:0]      active
);
   logic [26:0] shadow;
   logic        pending;
   logic        hit;

   assign hit = word_in.valid && (word_in.index == INDEX);

   // buffered writes wait here until the master word is written
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         shadow  <= RESET_VALUE;
         pending <= 1'b0;
      end else if (clk_en) begin
         if (hit && word_in.data[DBUF_BIT]) begin
            shadow  <= word_in.data; // see R1
            pending <= 1'b1;
         end else if (wr_master) begin
            pending <= 1'b0;
         end
      end
   end

   // direct write takes effect at once; pending shadow moves on master write
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         active <= RESET_VALUE;
      end else if (clk_en) begin
         if (hit && !word_in.data[DBUF_BIT]) begin
            active <= word_in.data; // see R24
         end else if (wr_master && pending) begin
            active <= shadow; // see R1
         end
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// two flip-flop synchroniser; only the second stage is read outside
module sync_stage #(
   parameter int WIDTH = 1
)
(
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic             clk_en,
   input  wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0]      sync_out
);
   logic [WIDTH-1:0] first;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         first    <= '0;
         sync_out <= '0;
      end else if (clk_en) begin
         first    <= async_in;
         sync_out <= first;
      end
   end
endmodule

// File: synth_regs_monitor.sv
// assertions for the synthesizer control word bank
// assumes one ref_clk domain; bound to the bank at the foot of this file
`timescale 1ns/10ps
module synth_regs_monitor
   import synth_regs_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        clk_en,
   input wire word_write_t word_in,
   input wire logic [1:0]  master_delay_value,
   input wire logic        compare_clk,
   input wire logic [7:0]  phase_error_cycles,
   input wire logic [26:0] modulus_and_output2_ctrl,
   input wire logic [26:0] ref_divider_and_leakage_ctrl,
   input wire logic [26:0] lock_detect_and_buffer_ctrl,
   input wire synth_ctrl_t ctrl,
   input wire logic [1:0]  down_split_level,
   input wire logic        output_mute,
   input wire logic        lock_indicator
);
   wire logic [26:0] m  = modulus_and_output2_ctrl;
   wire logic [26:0] r  = ref_divider_and_leakage_ctrl;
   wire logic        wr = word_in.valid && clk_en;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////
   AST_DIRECT: assert property (
      wr && word_in.index == IDX_REFDIV && !word_in.data[DBUF_BIT] |=> r == $past(word_in.data))
      else $error("direct write not applied");
   AST_SHADOW: assert property (
      wr && word_in.index == IDX_MODULUS && word_in.data[DBUF_BIT] |=> $stable(m))
      else $error("buffered write applied early");
   AST_MUTE: assert property (
      $past(clk_en) && !$past(rst) |-> output_mute == ($past(r[25]) |
      ($past(lock_detect_and_buffer_ctrl[7]) &
       ~(lock_indicator ^ $past(lock_detect_and_buffer_ctrl[6])))))
      else $error("mute does not follow lock state");
   AST_SHADOW2: assert property (
      wr && word_in.index == IDX_REFDIV && word_in.data[DBUF_BIT] |=> $stable(r))
      else $error("buffered write applied early");
   AST_IDLE: assert property (
      !wr && !$past(wr) |=> $stable(m) && $stable(r) && $stable(lock_detect_and_buffer_ctrl))
      else $error("word changed without a write");
   AST_LEAK: assert property (
      $past(clk_en) && !$past(rst) |-> ctrl.leakage_current_step == ($past(r[25]) ? 6'h00 :
      $past(r[24]) ? {$past(r[23:19]), 1'b0} : {1'b0, $past(r[23:19])}))
      else $error("leakage step wrong");
   AST_DELAY: assert property (
      $past(clk_en) && !$past(rst) |->
      ctrl.detector_delay_mode == (&$past(r[16:15]) ? 2'b00 : $past(r[16:15])))
      else $error("delay mode wrong");
   AST_SPLIT: assert property (
      clk_en && ctrl.down_split_enable && r[17] |=> down_split_level == $past(master_delay_value))
      else $error("down split level wrong");
   AST_PD_MUTE: assert property (
      clk_en && ctrl.device_power_down && r[25] |=> output_mute)
      else $error("power down without mute");
   AST_OUT2: assert property (
      $past(clk_en) && !$past(rst) |-> ctrl.output2_power_down == ($past(m[21]) | $past(r[25])))
      else $error("second output control wrong");
   cover property (wr && word_in.index == IDX_MASTER);
   cover property (lock_indicator != lock_detect_and_buffer_ctrl[6]);
   cover property (ctrl.device_power_down);
endmodule

bind synth_control_regs_2_to_4 synth_regs_monitor mon_u (.*);

// File: detector_source.sv
// detector side model: compare edges every 64 ns and a phase error
// assumes the clock stands still while run is low
`timescale 1ns/10ps
module detector_source (
   input  wire logic run,
   input  wire logic bad,
   output logic      compare_clk,
   output logic [7:0] phase_error_cycles
);
   initial begin
      compare_clk = 1'b0;
      phase_error_cycles = 8'h00;
   end
   // error moves on the falling edge so it is settled at the compare
   always begin
      #32;
      if (run) begin
         compare_clk = ~compare_clk;
         if (!compare_clk) phase_error_cycles = bad ? 8'h10 : 8'h00;
      end
   end
endmodule

// File: testbench.sv
// self-checking bench for the synthesizer control word bank
// assumes a 200 MHz ref_clk and compare edges from detector_source
`timescale 1ns/10ps
module testbench;
   import synth_regs_pkg::*;
   logic        ref_clk, rst, clk_en, run, bad, compare_clk, mute, lock;
   logic [1:0]  mdv, dsl;
   logic [7:0]  phase_error_cycles;
   logic [26:0] m, r, k;
   word_write_t word_in;
   synth_ctrl_t ctrl;
   int          n_fail, checks;

   synth_control_regs_2_to_4 dut_u (.ref_clk, .rst, .clk_en, .word_in,
      .master_delay_value(mdv), .compare_clk, .phase_error_cycles,
      .modulus_and_output2_ctrl(m), .ref_divider_and_leakage_ctrl(r),
      .lock_detect_and_buffer_ctrl(k), .ctrl, .down_split_level(dsl),
      .output_mute(mute), .lock_indicator(lock));
   detector_source src_u (.run, .bad, .compare_clk, .phase_error_cycles);
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [26:0] seen, input logic [26:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic wr(input logic [3:0] idx, input logic [26:0] d);
      cyc(1);
      word_in = '{1'b1, idx, d};
      cyc(1);
      word_in.valid = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      clk_en = 1'b1;
      run = 1'b0;
      bad = 1'b1;
      mdv = 2'b10;
      word_in = '0;
      n_fail = 0;
      checks = 0;
      cyc(6);
      rst = 1'b0;
      chk(m, MODULUS_RESET);
      chk(r, REFDIV_RESET);
      chk(k, LOCK_RESET);
      wr(IDX_REFDIV, {3'b001, 5'd5, 4'hf, 2'b10, 13'h0a5});
      chk(r, {3'b001, 5'd5, 4'hf, 2'b10, 13'h0a5});
      cyc(1);
      chk(ctrl.leakage_current_step, 6'd10);
      chk({ctrl.leakage_direction, ctrl.detector_delay_mode, ctrl.reference_path,
           ctrl.reference_divider}, {5'b10010, 13'h0a5});
      cyc(1);
      chk(dsl, 2'b10);
      wr(IDX_MODULUS, {6'h21, 21'h000123});
      cyc(2);
      chk(m, MODULUS_RESET);
      wr(IDX_MASTER, 27'h0);
      cyc(2);
      chk(m, {6'h21, 21'h000123});
      chk({ctrl.output2_power_down, ctrl.fraction_denominator}, 22'h200123);
      wr(IDX_LOCK, {7'h0, 1'b1, 4'h0, 3'b000, 2'b11, 2'b10, 2'b11, 6'h0});
      cyc(1);
      chk({ctrl.external_oscillator_enable, ctrl.internal_oscillator_on,
           ctrl.gain_compensation_auto, ctrl.detector_polarity,
           ctrl.reference_buffer_mode}, 6'b100110);
      chk({lock, mute}, 2'b11);
      run = 1'b1;
      bad = 1'b0;
      cyc(37);
      chk({lock, mute}, 2'b11);
      cyc(83);
      chk({lock, mute}, 2'b00);
      bad = 1'b1;
      cyc(30);
      chk({lock, mute}, 2'b11);
      bad = 1'b0;
      cyc(120);
      chk({lock, mute}, 2'b00);
      clk_en = 1'b0;
      wr(IDX_LOCK, 27'h0000309);
      cyc(2);
      chk(k, {7'h0, 1'b1, 4'h0, 3'b000, 2'b11, 2'b10, 2'b11, 6'h0});
      clk_en = 1'b1;
      wr(IDX_REFDIV, {2'b01, 25'h0});
      cyc(2);
      chk({mute, ctrl.device_power_down, ctrl.leakage_current_step}, 8'hc0);
      give_verdict;
   end

   initial begin
      #20000;
      n_fail++;
      give_verdict;
   end
endmodule
